// ==== timer16_irq_pkg.sv ====
// Constants shared by the timer interrupt enable and flag logic
package timer16_irq_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [7:0] IO_SPACE_MAX        = 8'h3F;
  localparam logic [7:0] IO_DATA_OFFSET      = 8'h20;
  localparam logic [7:0] EXT_IO_BASE         = 8'h60;
  localparam logic [7:0] FLAGS_IO_ADDR       = 8'h36;
  localparam logic [7:0] MASK_IO_ADDR        = 8'h37;
  localparam logic [7:0] EXT_FLAGS_DATA_ADDR = 8'h7C;
  localparam logic [7:0] EXT_MASK_DATA_ADDR  = 8'h7D;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET     = 8'h00;
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [7:0] EXT_MASK_RESET  = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // Bit positions within the flag and mask registers
  // ----------------------------------------------------------------
  localparam int CAPTURE_BIT = 5;
  localparam int CMPA_BIT    = 4;
  localparam int CMPB_BIT    = 3;
  localparam int OVF_BIT     = 2;
  localparam int T3_CMPC_BIT = 1;
  localparam int T1_CMPC_BIT = 0;

  // ----------------------------------------------------------------
  // Interrupt source indices
  // ----------------------------------------------------------------
  localparam int NUM_SOURCES = 10;
  localparam int SRC_T1_CAP  = 0;
  localparam int SRC_T1_CMPA = 1;
  localparam int SRC_T1_CMPB = 2;
  localparam int SRC_T1_OVF  = 3;
  localparam int SRC_T1_CMPC = 4;
  localparam int SRC_T3_CAP  = 5;
  localparam int SRC_T3_CMPA = 6;
  localparam int SRC_T3_CMPB = 7;
  localparam int SRC_T3_OVF  = 8;
  localparam int SRC_T3_CMPC = 9;

  // ----------------------------------------------------------------
  // Waveform mode tables, one bit per mode encoding
  // ----------------------------------------------------------------
  localparam logic [15:0] CAPTURE_TOP_MODES = 16'h5500;
  localparam logic [15:0] OVF_AT_WRAP_MODES = 16'h1011;
  localparam logic [15:0] OVF_AT_TOP_MODES  = 16'hC0E0;
  localparam logic [15:0] OVF_AT_BOT_MODES  = 16'h0F0E;

endpackage

// ==== timer_event_detect.sv ====
// Flag set conditions for one 16-bit timer
`timescale 1ns/10ps
module timer_event_detect #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic             timer_tick,
  input  wire logic [WIDTH-1:0] counter,
  input  wire logic [WIDTH-1:0] compare_a_value,
  input  wire logic [WIDTH-1:0] compare_b_value,
  input  wire logic [WIDTH-1:0] compare_c_value,
  input  wire logic [3:0]       waveform_mode_bits,
  input  wire logic             capture_pin,
  input  wire logic             at_top,
  input  wire logic             at_bottom,
  input  wire logic             wrap,
  output logic                  set_capture,
  output logic                  set_cmpa,
  output logic                  set_cmpb,
  output logic                  set_cmpc,
  output logic                  set_ovf
);

  logic [2:0] match_r;
  logic [2:0] match_nxt;
  logic       pin_r;
  wire        capture_top_mode = timer16_irq_pkg::CAPTURE_TOP_MODES[waveform_mode_bits];
  wire        pin_edge         = capture_pin & ~pin_r;

  // ----------------------------------------------------------------
  // Compare match, flagged one timer clock later
  // ----------------------------------------------------------------
  // only counter equality
  assign match_nxt = {counter == compare_c_value, counter == compare_b_value, counter == compare_a_value};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      match_r <= '0;
      pin_r   <= 1'b0;
    end else if (ce && timer_tick) begin
      match_r <= match_nxt;
      pin_r   <= capture_pin;
    end
  end

  assign set_cmpa = timer_tick & match_r[0];
  assign set_cmpb = timer_tick & match_r[1];
  assign set_cmpc = timer_tick & match_r[2];

  // ----------------------------------------------------------------
  // Capture and overflow
  // ----------------------------------------------------------------
  // pin or top
  assign set_capture = timer_tick & (capture_top_mode ? at_top : pin_edge);

  assign set_ovf = timer_tick &
                   ((timer16_irq_pkg::OVF_AT_WRAP_MODES[waveform_mode_bits] & wrap) |
                    (timer16_irq_pkg::OVF_AT_TOP_MODES[waveform_mode_bits] & at_top) |
                    (timer16_irq_pkg::OVF_AT_BOT_MODES[waveform_mode_bits] & at_bottom));

endmodule

// ==== irq_flag_bank.sv ====
// Sticky interrupt flags with set-over-clear priority
`timescale 1ns/10ps
module irq_flag_bank #(
  parameter int N = 10
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [N-1:0] set_pulse,
  input  wire logic [N-1:0] write_clear,
  input  wire logic [N-1:0] vector_clear,
  output logic      [N-1:0] flags_r
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      logic flag_nxt;
      assign flag_nxt = set_pulse[i] | (flags_r[i] & ~write_clear[i] & ~vector_clear[i]);

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          flags_r[i] <= 1'b0;
        end else if (ce) begin
          flags_r[i] <= flag_nxt;
        end
      end
    end
  endgenerate

endmodule

// ==== timer16_irq_mask_flags.sv ====
// Interrupt enables, flags and requests for timers 1 and 3
`timescale 1ns/10ps

module timer16_irq_mask_flags #(
  parameter int WIDTH = 16
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic [7:0]          addr,
  input  wire logic                addr_is_io,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  input  wire logic [7:0]          wdata,
  input  wire logic                legacy_mode,
  input  wire logic                global_irq_enable,
  input  wire logic                vector_ack,
  input  wire logic [3:0]          vector_id,
  input  wire logic                t1_tick,
  input  wire logic [WIDTH-1:0]    t1_counter,
  input  wire logic [WIDTH-1:0]    t1_compare_a_value,
  input  wire logic [WIDTH-1:0]    t1_compare_b_value,
  input  wire logic [WIDTH-1:0]    t1_compare_c_value,
  input  wire logic [3:0]          t1_waveform_mode_bits,
  input  wire logic                t1_capture_pin,
  input  wire logic                t1_at_top,
  input  wire logic                t1_at_bottom,
  input  wire logic                t1_wrap,
  input  wire logic                t3_tick,
  input  wire logic [WIDTH-1:0]    t3_counter,
  input  wire logic [WIDTH-1:0]    t3_compare_a_value,
  input  wire logic [WIDTH-1:0]    t3_compare_b_value,
  input  wire logic [WIDTH-1:0]    t3_compare_c_value,
  input  wire logic [3:0]          t3_waveform_mode_bits,
  input  wire logic                t3_capture_pin,
  input  wire logic                t3_at_top,
  input  wire logic                t3_at_bottom,
  input  wire logic                t3_wrap,
  output logic      [7:0]          rdata_r,
  output logic      [timer16_irq_pkg::NUM_SOURCES-1:0] irq_req_r
);

  localparam int NS = timer16_irq_pkg::NUM_SOURCES;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]    timer_irq_mask_r;
  logic [7:0]    timer_irq_mask_nxt;
  logic [7:0]    extended_timer_irq_enables_r;
  logic [7:0]    extended_timer_irq_enables_nxt;
  logic [7:0]    rdata_nxt;
  logic [NS-1:0] irq_req_nxt;
  logic [NS-1:0] flags_r;
  logic [NS-1:0] set_pulse;
  logic [NS-1:0] write_clear;
  logic [NS-1:0] vector_clear;
  logic [NS-1:0] enables;
  logic [7:0]    timer_irq_flags;
  logic [7:0]    extended_timer_irq_flags;

  wire t1_set_cap;
  wire t1_set_cmpa;
  wire t1_set_cmpb;
  wire t1_set_cmpc;
  wire t1_set_ovf;
  wire t3_set_cap;
  wire t3_set_cmpa;
  wire t3_set_cmpb;
  wire t3_set_cmpc;
  wire t3_set_ovf;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // I/O plus offset
  wire       io_in_range = addr <= timer16_irq_pkg::IO_SPACE_MAX;
  wire [7:0] data_addr   = addr_is_io ? 8'(addr + timer16_irq_pkg::IO_DATA_OFFSET) : addr;
  wire       addr_valid  = ~addr_is_io | io_in_range;

  wire [7:0] flags_data_addr = 8'(timer16_irq_pkg::FLAGS_IO_ADDR + timer16_irq_pkg::IO_DATA_OFFSET);
  wire [7:0] mask_data_addr  = 8'(timer16_irq_pkg::MASK_IO_ADDR + timer16_irq_pkg::IO_DATA_OFFSET);

  wire ext_space = ~addr_is_io & (addr >= timer16_irq_pkg::EXT_IO_BASE);

  wire hit_flags     = addr_valid & (data_addr == flags_data_addr);
  wire hit_mask      = addr_valid & (data_addr == mask_data_addr);
  wire hit_ext_flags = ext_space & (addr == timer16_irq_pkg::EXT_FLAGS_DATA_ADDR);
  wire hit_ext_mask  = ext_space & ~legacy_mode & (addr == timer16_irq_pkg::EXT_MASK_DATA_ADDR);

  wire wr_flags     = wr_en & hit_flags;
  wire wr_mask      = wr_en & hit_mask;
  wire wr_ext_flags = wr_en & hit_ext_flags;
  wire wr_ext_mask  = wr_en & hit_ext_mask;

  // ----------------------------------------------------------------
  // Event detectors
  // ----------------------------------------------------------------
  timer_event_detect #(
    .WIDTH (WIDTH)
  ) u_t1_events (
    .clk                (clk),
    .reset              (reset),
    .ce                 (ce),
    .timer_tick         (t1_tick),
    .counter            (t1_counter),
    .compare_a_value    (t1_compare_a_value),
    .compare_b_value    (t1_compare_b_value),
    .compare_c_value    (t1_compare_c_value),
    .waveform_mode_bits (t1_waveform_mode_bits),
    .capture_pin        (t1_capture_pin),
    .at_top             (t1_at_top),
    .at_bottom          (t1_at_bottom),
    .wrap               (t1_wrap),
    .set_capture        (t1_set_cap),
    .set_cmpa           (t1_set_cmpa),
    .set_cmpb           (t1_set_cmpb),
    .set_cmpc           (t1_set_cmpc),
    .set_ovf            (t1_set_ovf)
  );

  timer_event_detect #(
    .WIDTH (WIDTH)
  ) u_t3_events (
    .clk                (clk),
    .reset              (reset),
    .ce                 (ce),
    .timer_tick         (t3_tick),
    .counter            (t3_counter),
    .compare_a_value    (t3_compare_a_value),
    .compare_b_value    (t3_compare_b_value),
    .compare_c_value    (t3_compare_c_value),
    .waveform_mode_bits (t3_waveform_mode_bits),
    .capture_pin        (t3_capture_pin),
    .at_top             (t3_at_top),
    .at_bottom          (t3_at_bottom),
    .wrap               (t3_wrap),
    .set_capture        (t3_set_cap),
    .set_cmpa           (t3_set_cmpa),
    .set_cmpb           (t3_set_cmpb),
    .set_cmpc           (t3_set_cmpc),
    .set_ovf            (t3_set_ovf)
  );

  assign set_pulse[timer16_irq_pkg::SRC_T1_CAP]  = t1_set_cap;
  assign set_pulse[timer16_irq_pkg::SRC_T1_CMPA] = t1_set_cmpa;
  assign set_pulse[timer16_irq_pkg::SRC_T1_CMPB] = t1_set_cmpb;
  assign set_pulse[timer16_irq_pkg::SRC_T1_OVF]  = t1_set_ovf;
  assign set_pulse[timer16_irq_pkg::SRC_T1_CMPC] = t1_set_cmpc;
  assign set_pulse[timer16_irq_pkg::SRC_T3_CAP]  = t3_set_cap;
  assign set_pulse[timer16_irq_pkg::SRC_T3_CMPA] = t3_set_cmpa;
  assign set_pulse[timer16_irq_pkg::SRC_T3_CMPB] = t3_set_cmpb;
  assign set_pulse[timer16_irq_pkg::SRC_T3_OVF]  = t3_set_ovf;
  assign set_pulse[timer16_irq_pkg::SRC_T3_CMPC] = t3_set_cmpc;

  // ----------------------------------------------------------------
  // Flag clears
  // ----------------------------------------------------------------
  // write one clears
  assign write_clear[timer16_irq_pkg::SRC_T1_CAP]  = wr_flags & wdata[timer16_irq_pkg::CAPTURE_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T1_CMPA] = wr_flags & wdata[timer16_irq_pkg::CMPA_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T1_CMPB] = wr_flags & wdata[timer16_irq_pkg::CMPB_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T1_OVF]  = wr_flags & wdata[timer16_irq_pkg::OVF_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T1_CMPC] = wr_ext_flags & wdata[timer16_irq_pkg::T1_CMPC_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T3_CAP]  = wr_ext_flags & wdata[timer16_irq_pkg::CAPTURE_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T3_CMPA] = wr_ext_flags & wdata[timer16_irq_pkg::CMPA_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T3_CMPB] = wr_ext_flags & wdata[timer16_irq_pkg::CMPB_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T3_OVF]  = wr_ext_flags & wdata[timer16_irq_pkg::OVF_BIT];
  assign write_clear[timer16_irq_pkg::SRC_T3_CMPC] = wr_ext_flags & wdata[timer16_irq_pkg::T3_CMPC_BIT];

  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : g_vec
      assign vector_clear[s] = vector_ack & (vector_id == 4'(s));
    end
  endgenerate

  irq_flag_bank #(
    .N (NS)
  ) u_flags (
    .clk          (clk),
    .reset        (reset),
    .ce           (ce),
    .set_pulse    (set_pulse),
    .write_clear  (write_clear),
    .vector_clear (vector_clear),
    .flags_r      (flags_r)
  );

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  // main flag layout
  always_comb begin
    timer_irq_flags                                  = timer16_irq_pkg::READ_ZERO;
    timer_irq_flags[timer16_irq_pkg::CAPTURE_BIT]    = flags_r[timer16_irq_pkg::SRC_T1_CAP];
    timer_irq_flags[timer16_irq_pkg::CMPA_BIT]       = flags_r[timer16_irq_pkg::SRC_T1_CMPA];
    timer_irq_flags[timer16_irq_pkg::CMPB_BIT]       = flags_r[timer16_irq_pkg::SRC_T1_CMPB];
    timer_irq_flags[timer16_irq_pkg::OVF_BIT]        = flags_r[timer16_irq_pkg::SRC_T1_OVF];
  end

  always_comb begin
    extended_timer_irq_flags                               = timer16_irq_pkg::READ_ZERO;
    extended_timer_irq_flags[timer16_irq_pkg::CAPTURE_BIT] = flags_r[timer16_irq_pkg::SRC_T3_CAP];
    extended_timer_irq_flags[timer16_irq_pkg::CMPA_BIT]    = flags_r[timer16_irq_pkg::SRC_T3_CMPA];
    extended_timer_irq_flags[timer16_irq_pkg::CMPB_BIT]    = flags_r[timer16_irq_pkg::SRC_T3_CMPB];
    extended_timer_irq_flags[timer16_irq_pkg::OVF_BIT]     = flags_r[timer16_irq_pkg::SRC_T3_OVF];
    extended_timer_irq_flags[timer16_irq_pkg::T3_CMPC_BIT] = flags_r[timer16_irq_pkg::SRC_T3_CMPC];
    extended_timer_irq_flags[timer16_irq_pkg::T1_CMPC_BIT] = flags_r[timer16_irq_pkg::SRC_T1_CMPC];
  end

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  // writable timer1 bits
  wire [7:0] mask_bits = 8'((1 << timer16_irq_pkg::CAPTURE_BIT) | (1 << timer16_irq_pkg::CMPA_BIT) |
                            (1 << timer16_irq_pkg::CMPB_BIT) | (1 << timer16_irq_pkg::OVF_BIT));
  wire [7:0] ext_mask_bits = 8'(mask_bits | (1 << timer16_irq_pkg::T3_CMPC_BIT) |
                                (1 << timer16_irq_pkg::T1_CMPC_BIT));

  assign timer_irq_mask_nxt             = wr_mask ? (wdata & mask_bits) : timer_irq_mask_r;
  assign extended_timer_irq_enables_nxt = wr_ext_mask ? (wdata & ext_mask_bits) : extended_timer_irq_enables_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_irq_mask_r             <= timer16_irq_pkg::MASK_RESET;
      extended_timer_irq_enables_r <= timer16_irq_pkg::EXT_MASK_RESET;
    end else if (ce) begin
      timer_irq_mask_r             <= timer_irq_mask_nxt;
      extended_timer_irq_enables_r <= extended_timer_irq_enables_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Enables and requests
  // ----------------------------------------------------------------
  // extended enables off in legacy
  wire [7:0] ext_en = legacy_mode ? timer16_irq_pkg::READ_ZERO : extended_timer_irq_enables_r;

  assign enables[timer16_irq_pkg::SRC_T1_CAP]  = timer_irq_mask_r[timer16_irq_pkg::CAPTURE_BIT];
  assign enables[timer16_irq_pkg::SRC_T1_CMPA] = timer_irq_mask_r[timer16_irq_pkg::CMPA_BIT];
  assign enables[timer16_irq_pkg::SRC_T1_CMPB] = timer_irq_mask_r[timer16_irq_pkg::CMPB_BIT];
  assign enables[timer16_irq_pkg::SRC_T1_OVF]  = timer_irq_mask_r[timer16_irq_pkg::OVF_BIT];
  assign enables[timer16_irq_pkg::SRC_T1_CMPC] = ext_en[timer16_irq_pkg::T1_CMPC_BIT];
  assign enables[timer16_irq_pkg::SRC_T3_CAP]  = ext_en[timer16_irq_pkg::CAPTURE_BIT];
  assign enables[timer16_irq_pkg::SRC_T3_CMPA] = ext_en[timer16_irq_pkg::CMPA_BIT];
  assign enables[timer16_irq_pkg::SRC_T3_CMPB] = ext_en[timer16_irq_pkg::CMPB_BIT];
  assign enables[timer16_irq_pkg::SRC_T3_OVF]  = ext_en[timer16_irq_pkg::OVF_BIT];
  assign enables[timer16_irq_pkg::SRC_T3_CMPC] = ext_en[timer16_irq_pkg::T3_CMPC_BIT];

  assign irq_req_nxt = flags_r & enables & {NS{global_irq_enable}};

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign rdata_nxt = ~rd_en         ? rdata_r :
                     hit_flags      ? timer_irq_flags :
                     hit_mask       ? timer_irq_mask_r :
                     hit_ext_flags  ? extended_timer_irq_flags :
                     hit_ext_mask   ? extended_timer_irq_enables_r :
                                      timer16_irq_pkg::READ_ZERO;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r   <= timer16_irq_pkg::READ_ZERO;
      irq_req_r <= '0;
    end else if (ce) begin
      rdata_r   <= rdata_nxt;
      irq_req_r <= irq_req_nxt;
    end
  end

endmodule

// ==== timer16_irq_mask_flags_properties.sv ====
// Assertions on the timer interrupt enable and flag block
`timescale 1ns/10ps
module timer16_irq_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       ce,
  input wire logic [7:0] addr,
  input wire logic       addr_is_io,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] wdata,
  input wire logic       legacy_mode,
  input wire logic       global_irq_enable,
  input wire logic       vector_ack,
  input wire logic [3:0] vector_id,
  input wire logic       t1_tick,
  input wire logic       t3_tick,
  input wire logic [7:0] rdata_r,
  input wire logic [timer16_irq_pkg::NUM_SOURCES-1:0] irq_req_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  wire logic [7:0] data_addr = addr_is_io ? addr + 8'h20 : addr;
  wire logic       io_ok     = !addr_is_io || addr <= 8'h3F;
  wire logic       main_rd   = rd_en && ce && io_ok && (data_addr == 8'h56 || data_addr == 8'h57);
  wire logic       ext_rd    = rd_en && ce && !addr_is_io && (addr == 8'h7C || addr == 8'h7D);
  wire logic       no_tick   = !t1_tick && !t3_tick;

  property p_req_needs_global; $past(ce) && (|irq_req_r) |-> $past(global_irq_enable); endproperty
  a_req_needs_global: assert property (p_req_needs_global) else $error("request without global enable");
  property p_legacy_no_ext_req; $past(ce) && $past(legacy_mode) |-> irq_req_r[9:4] == 6'h00; endproperty
  a_legacy_no_ext_req: assert property (p_legacy_no_ext_req) else $error("extended request in legacy");
  property p_io_beyond; rd_en && ce && addr_is_io && addr > 8'h3F |=> rdata_r == 8'h00; endproperty
  a_io_beyond: assert property (p_io_beyond) else $error("io read beyond space not zero");
  property p_mask_hidden; rd_en && ce && !addr_is_io && addr == 8'h7D && legacy_mode |=> rdata_r == 8'h00; endproperty
  a_mask_hidden: assert property (p_mask_hidden) else $error("extended mask visible in legacy");
  property p_main_unused; main_rd |=> rdata_r[7:6] == 2'h0 && rdata_r[1:0] == 2'h0; endproperty
  a_main_unused: assert property (p_main_unused) else $error("unused main bits set");
  property p_ext_unused; ext_rd |=> rdata_r[7:6] == 2'h0; endproperty
  a_ext_unused: assert property (p_ext_unused) else $error("unused extended bits set");
  property p_vector_clear; vector_ack && ce && no_tick && vector_id < 4'hA ##1 ce |=> !irq_req_r[$past(vector_id, 2)]; endproperty
  a_vector_clear: assert property (p_vector_clear) else $error("request kept after vector");
  property p_w1c; wr_en && ce && addr_is_io && addr == 8'h36 && wdata[4] && no_tick ##1 ce |=> !irq_req_r[1]; endproperty
  a_w1c: assert property (p_w1c) else $error("request kept after write one");

  c_vector: cover property (vector_ack);
  c_request: cover property (|irq_req_r);
  c_legacy_read: cover property (rd_en && legacy_mode);
endmodule

bind timer16_irq_mask_flags timer16_irq_checker i_timer16_irq_checker (
  .clk, .reset, .ce, .addr, .addr_is_io, .wr_en, .rd_en, .wdata, .legacy_mode, .global_irq_enable,
  .vector_ack, .vector_id, .t1_tick, .t3_tick, .rdata_r, .irq_req_r
);

// ==== cpu_core_model.sv ====
// CPU core model: register access and interrupt vectoring
`timescale 1ns/10ps
module cpu_core_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata_r,
  input  wire logic [9:0] irq_req_r,
  input  wire logic       auto_ack,
  output logic      [7:0] addr = 8'hFF,
  output logic            addr_is_io = 1'b0,
  output logic            wr_en = 1'b0,
  output logic            rd_en = 1'b0,
  output logic      [7:0] wdata = 8'h00,
  output logic            vector_ack = 1'b0,
  output logic      [3:0] vector_id = 4'h0
);
  task automatic access(input logic [7:0] a, input logic io, input logic wr, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    addr_is_io <= io;
    wdata <= d;
    wr_en <= wr;
    rd_en <= !wr;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    @(posedge clk);
    #1 q = rdata_r;
  endtask

  always @(posedge clk) begin
    vector_ack <= 1'b0;
    if (auto_ack && !vector_ack) begin
      for (int i = 9; i >= 0; i--) begin
        if (irq_req_r[i]) begin
          vector_ack <= 1'b1;
          vector_id  <= 4'(i);
        end
      end
    end
  end
endmodule

// ==== tb.sv ====
// Testbench for the timer interrupt enable and flag block
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb;
  typedef struct packed {logic [7:0] a; logic io; logic [7:0] w; logic [7:0] e;} row_type;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        idle = 1'b0;
  logic        legacy_mode = 1'b0;
  logic        global_irq_enable = 1'b0;
  logic        auto_ack = 1'b0;
  logic        t1_tick = 1'b0;
  logic        t3_tick = 1'b0;
  logic        t1_capture_pin = 1'b0;
  logic        t1_at_top = 1'b0;
  logic        t1_wrap = 1'b0;
  logic        t1_at_bottom = 1'b0;
  logic [3:0]  t1_mode = 4'h0;
  logic [3:0]  t3_mode = 4'h0;
  logic [15:0] t1_counter = 16'h0000;
  logic [15:0] t3_counter = 16'h0000;
  logic [15:0] cmp_a = 16'h0100;
  logic [15:0] cmp_b = 16'h0200;
  logic [15:0] cmp_c = 16'h0300;
  logic [7:0]  addr, wdata, rdata_r;
  logic        addr_is_io, wr_en, rd_en, vector_ack;
  logic [3:0]  vector_id;
  logic [9:0]  irq_req_r;
  int          n_errors = 0;
  int          checked = 0;
  row_type     rows [6] = '{'{8'h37, 1'b1, 8'hFF, 8'h3C}, '{8'h57, 1'b0, 8'h14, 8'h14}, '{8'h7D, 1'b0, 8'hFF, 8'h3F},
                            '{8'h7D, 1'b1, 8'h00, 8'h00}, '{8'h10, 1'b0, 8'hFF, 8'h00}, '{8'h36, 1'b1, 8'h00, 8'h00}};

  timer16_irq_mask_flags i_timer16_irq_mask_flags (
    .clk, .reset, .ce, .addr, .addr_is_io, .wr_en, .rd_en, .wdata, .legacy_mode, .global_irq_enable,
    .vector_ack, .vector_id, .t1_tick, .t1_counter, .t1_compare_a_value(cmp_a), .t1_compare_b_value(cmp_b),
    .t1_compare_c_value(cmp_c), .t1_waveform_mode_bits(t1_mode), .t1_capture_pin, .t1_at_top,
    .t1_at_bottom, .t1_wrap, .t3_tick, .t3_counter, .t3_compare_a_value(cmp_a),
    .t3_compare_b_value(cmp_b), .t3_compare_c_value(cmp_c), .t3_waveform_mode_bits(t3_mode),
    .t3_capture_pin(idle), .t3_at_top(idle), .t3_at_bottom(idle), .t3_wrap(idle), .rdata_r, .irq_req_r
  );
  cpu_core_model i_cpu_core_model (
    .clk, .rdata_r, .irq_req_r, .auto_ack, .addr, .addr_is_io, .wr_en, .rd_en, .wdata, .vector_ack, .vector_id
  );

  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    logic [7:0] q;
    i_cpu_core_model.access(a, io, 1'b1, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic io, input logic [7:0] e);
    logic [7:0] q;
    i_cpu_core_model.access(a, io, 1'b0, 8'h00, q);
    `CHK(q, e)
  endtask
  // One timer clock cycle on both timers
  task automatic tk(input logic [15:0] c1, input logic [15:0] c3, input logic pin, input logic top, input logic wrp);
    @(posedge clk);
    t1_counter <= c1;
    t3_counter <= c3;
    t1_capture_pin <= pin;
    t1_at_top <= top;
    t1_wrap <= wrp;
    t1_tick <= 1'b1;
    t3_tick <= 1'b1;
    @(posedge clk);
    t1_tick <= 1'b0;
    t3_tick <= 1'b0;
    t1_at_top <= 1'b0;
    t1_wrap <= 1'b0;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial forever #20 clk = ~clk;
  initial begin
    #40000;
    n_errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk(8'h36, 1'b1, 8'h00);
    rd_chk(8'h7D, 1'b0, 8'h00);
    rd_chk(8'h7C, 1'b0, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].io, rows[i].w);
      rd_chk(rows[i].a, rows[i].io, rows[i].e);
    end
    rd_chk(8'h7D, 1'b0, 8'h3F);
    $display("registers done");
    @(posedge clk) legacy_mode <= 1'b1;
    rd_chk(8'h7D, 1'b0, 8'h00);
    wr(8'h7D, 1'b0, 8'h00);
    @(posedge clk) legacy_mode <= 1'b0;
    rd_chk(8'h7D, 1'b0, 8'h3F);
    $display("legacy done");
    @(posedge clk) global_irq_enable <= 1'b1;
    tk(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
    rd_chk(8'h36, 1'b1, 8'h00);
    tk(16'h0101, 16'h0000, 1'b0, 1'b0, 1'b0);
    rd_chk(8'h36, 1'b1, 8'h10);
    `CHK(irq_req_r, 10'h002)
    @(posedge clk) global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(irq_req_r, 10'h000)
    @(posedge clk) global_irq_enable <= 1'b1;
    wr(8'h36, 1'b1, 8'h00);
    rd_chk(8'h36, 1'b1, 8'h10);
    `CHK(irq_req_r, 10'h002)
    wr(8'h36, 1'b1, 8'h10);
    rd_chk(8'h36, 1'b1, 8'h00);
    `CHK(irq_req_r, 10'h000)
    $display("compare done");
    tk(16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0);
    rd_chk(8'h36, 1'b1, 8'h20);
    wr(8'h36, 1'b1, 8'h20);
    @(posedge clk) t1_mode <= 4'hC;
    tk(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
    tk(16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0);
    rd_chk(8'h36, 1'b1, 8'h00);
    tk(16'h0000, 16'h0000, 1'b1, 1'b1, 1'b0);
    rd_chk(8'h36, 1'b1, 8'h20);
    @(posedge clk) t1_mode <= 4'h0;
    tk(16'h0000, 16'h0000, 1'b1, 1'b0, 1'b1);
    rd_chk(8'h36, 1'b1, 8'h24);
    tk(16'h0300, 16'h0300, 1'b1, 1'b0, 1'b0);
    tk(16'h0301, 16'h0301, 1'b1, 1'b0, 1'b0);
    rd_chk(8'h7C, 1'b0, 8'h03);
    rd_chk(8'h7C, 1'b1, 8'h00);
    rd_chk(8'h36, 1'b1, 8'h24);
    $display("events done");
    @(posedge clk) global_irq_enable <= 1'b1;
    auto_ack <= 1'b1;
    repeat (20) @(posedge clk);
    auto_ack <= 1'b0;
    rd_chk(8'h36, 1'b1, 8'h20);
    rd_chk(8'h7C, 1'b0, 8'h00);
    `CHK(irq_req_r, 10'h000)
    $display("vectors done");
    wr(8'h36, 1'b1, 8'h20);
    @(posedge clk) t1_mode <= 4'hD;
    t1_at_bottom <= 1'b1;
    tk(16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1);
    rd_chk(8'h36, 1'b1, 8'h00);
    @(posedge clk) t1_mode <= 4'h1;
    tk(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
    rd_chk(8'h36, 1'b1, 8'h04);
    `CHK(irq_req_r, 10'h008)
    wr(8'h36, 1'b1, 8'h04);
    @(posedge clk) t1_mode <= 4'h5;
    tk(16'h0000, 16'h0000, 1'b0, 1'b1, 1'b0);
    rd_chk(8'h36, 1'b1, 8'h04);
    @(posedge clk) ce <= 1'b0;
    wr(8'h37, 1'b1, 8'h00);
    @(posedge clk) ce <= 1'b1;
    rd_chk(8'h37, 1'b1, 8'h14);
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    rd_chk(8'h7D, 1'b0, 8'h00);
    `CHK(irq_req_r, 10'h000)
    $display("corner cases done");
    close_out();
  end
endmodule
